/* design/gph_consts.svh */
`ifndef GPH_CONSTS_SVH
`define GPH_CONSTS_SVH
// frame layout
`define GPH_FRAME_LEN     4'h9
`define GPH_LAST_IDX      4'h8
`define GPH_MOD_ADDR      8'h01
`define GPH_HOST_ADDR     8'h02
// instruction codes
`define GPH_OP_RD_GP      8'h0a
`define GPH_OP_ST_GP      8'h0b
`define GPH_OP_RS_GP      8'h0c
`define GPH_OP_HOME       8'h0d
`define GPH_OP_SET_OUT    8'h0e
// banks
`define GPH_BANK_GLOBAL   8'h00
`define GPH_BANK_USER     8'h02
`define GPH_BANK_IRQ      8'h03
// home search types
`define GPH_HOME_START    8'h00
`define GPH_HOME_STOP     8'h01
`define GPH_HOME_STATUS   8'h02
// output line selection
`define GPH_OUT_ALL       8'hff
`define GPH_OUT_LINES     8'h08
`define GPH_VAL_ACCU      32'hffffffff
// reply status codes
`define GPH_ST_OK         8'h64
`define GPH_ST_BAD_CK     8'h01
`define GPH_ST_BAD_CMD    8'h02
`define GPH_ST_BAD_TYPE   8'h03
`define GPH_ST_BAD_VAL    8'h04
// reset values
`define GPH_DOUT_RST      8'h00
`define GPH_ACCU_RST      32'h00000000
`endif

/* design/gph_pkg.sv */
`default_nettype none
package gph_pkg;
   typedef enum logic [5:0] {
      ST_BOOT = 6'h01,
      ST_RX   = 6'h02,
      ST_EXEC = 6'h04,
      ST_RD   = 6'h08,
      ST_WR   = 6'h10,
      ST_TX   = 6'h20
   } gph_state_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'h1,
      HS_RUN  = 2'h2
   } gph_home_t;

   typedef enum logic [1:0] {
      MOP_READ    = 2'h0,
      MOP_STORE   = 2'h1,
      MOP_RESTORE = 2'h2,
      MOP_BOOT    = 2'h3
   } gph_memop_t;
endpackage
`default_nettype wire

/* design/gph_mem_if.sv */
`default_nettype none
interface gph_mem_if #(parameter int AW = 10, parameter int DW = 32);
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport owner (output addr, output we, output wdata, input rdata);
   modport mem   (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

/* design/gph_mem.sv */
`default_nettype none
module gph_mem #(
   parameter int AW = 10,
   parameter int DW = 32
) (
   // clock
   input  wire logic clk,
   input  wire logic ce,
   // access port
   gph_mem_if.mem    port
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // synchronous write, registered read
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (port.we)
            store[port.addr] <= port.wdata;
         port.rdata <= store[port.addr];
      end
   end
endmodule
`default_nettype wire

/* design/gph_top.sv */
// Contract
// - code 10 reads global parameter into accumulator
// - bank 0 global, 2 user, 3 interrupt
// - read reply: status 100, value read
// - code 11 bank 2 stores user variable
// - bank 0 writes commit to nonvolatile automatically
// - code 12 bank 2 reloads user variable
// - power-up reloads all user variables
// - code 13: start 0, stop 1, status 2
// - home search machine: start, stop, query
// - status query: 0 idle, nonzero running
// - code 14 bank 2 sets one line
// - type 255 sets all lines, -1 uses accumulator
// - reply: host, target, status, instr, value, checksum
`include "gph_consts.svh"
`default_nettype none
module gph_top
   import gph_pkg::*;
#(
   parameter logic [7:0] MOD_ADDR   = `GPH_MOD_ADDR,
   parameter logic [7:0] HOST_ADDR  = `GPH_HOST_ADDR,
   parameter bit         RESTORE_EN = 1'b1
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // command byte stream
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // reply byte stream
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // global parameter write port
   input  wire logic        gp_wr_valid,
   input  wire logic [7:0]  gp_wr_bank,
   input  wire logic [7:0]  gp_wr_type,
   input  wire logic [31:0] gp_wr_data,
   // home search
   input  wire logic        home_found,
   output logic             home_active,
   // outputs and status
   output logic [7:0]       out_lines,
   output logic [31:0]      accu,
   output logic             busy
);
   gph_state_t    state;
   gph_state_t    next_state;
   gph_home_t     home;
   gph_memop_t    mop;
   gph_memop_t    next_mop;
   logic [7:0]    fb [0:7];
   logic [3:0]    rx_cnt;
   logic [7:0]    rx_sum;
   logic          ck_ok;
   logic [9:0]    cur_addr;
   logic [9:0]    next_addr;
   logic [7:0]    r_status;
   logic [7:0]    next_status;
   logic [31:0]   r_value;
   logic [31:0]   next_value;
   logic [3:0]    tx_idx;
   logic [7:0]    tx_sum;
   logic          home_s1;
   logic          home_s2;
   logic          hs_start;
   logic          hs_stop;
   logic          sio_we;
   logic [7:0]    sio_mask;
   logic [7:0]    sio_val;
   logic          go_mem;
   logic          rx_take;
   logic          frame_end;
   logic          tx_go;
   logic          tx_step;
   logic [7:0]    c_instr;
   logic [7:0]    c_type;
   logic [7:0]    c_bank;
   logic [31:0]   c_val;

   gph_mem_if #(.AW(10), .DW(32)) work_if ();
   gph_mem_if #(.AW(10), .DW(32)) nv_if ();

   gph_mem #(.AW(10), .DW(32)) u_work (
      .clk  (clk),
      .ce   (ce),
      .port (work_if)
   );

   gph_mem #(.AW(10), .DW(32)) u_nv (
      .clk  (clk),
      .ce   (ce),
      .port (nv_if)
   );

   // bank and type form the memory address
   function automatic logic [9:0] gp_addr(input logic [7:0] bank, input logic [7:0] typ);
      return {bank[1:0], typ};
   endfunction

   function automatic logic bank_ok(input logic [7:0] bank);
      return (bank == `GPH_BANK_GLOBAL) || (bank == `GPH_BANK_USER)
          || (bank == `GPH_BANK_IRQ);
   endfunction

   assign c_instr   = fb[1];
   assign c_type    = fb[2];
   assign c_bank    = fb[3];
   assign c_val     = {fb[4], fb[5], fb[6], fb[7]};
   assign rx_take   = ce && (state == ST_RX) && rx_valid;
   assign frame_end = rx_take && (rx_cnt == `GPH_LAST_IDX);
   assign tx_step   = tx_valid && tx_ready;
   assign tx_go     = (state != ST_TX) && (next_state == ST_TX);

   // home found pin synchroniser
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         home_s1 <= 1'b0;
         home_s2 <= 1'b0;
      end
      else if (ce)
      begin
         home_s1 <= home_found;
         home_s2 <= home_s1;
      end
   end

   // frame receive and checksum
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_cnt <= 4'h0;
         rx_sum <= 8'h00;
         ck_ok  <= 1'b0;
         for (int i = 0; i < 8; i++)
            fb[i] <= 8'h00;
      end
      else if (rx_take)
      begin
         if (rx_cnt == `GPH_LAST_IDX)
         begin
            ck_ok  <= (rx_data == rx_sum);
            rx_cnt <= 4'h0;
            rx_sum <= 8'h00;
         end
         else
         begin
            fb[rx_cnt[2:0]] <= rx_data;
            rx_sum          <= rx_sum + rx_data;
            rx_cnt          <= rx_cnt + 4'h1;
         end
      end
   end

   // command decode
   always_comb
   begin
      next_status = `GPH_ST_OK;
      next_value  = 32'h00000000;
      next_mop    = MOP_READ;
      next_addr   = gp_addr(c_bank, c_type);
      go_mem      = 1'b0;
      hs_start    = 1'b0;
      hs_stop     = 1'b0;
      sio_we      = 1'b0;
      sio_mask    = 8'h00;
      sio_val     = 8'h00;
      if (!ck_ok)
         next_status = `GPH_ST_BAD_CK;
      else
      begin
         case (c_instr)
            `GPH_OP_RD_GP:
            begin
               if (bank_ok(c_bank))
                  go_mem = 1'b1;
               else
                  next_status = `GPH_ST_BAD_VAL;
            end
            `GPH_OP_ST_GP, `GPH_OP_RS_GP:
            begin
               next_mop = (c_instr == `GPH_OP_ST_GP) ? MOP_STORE : MOP_RESTORE;
               if (c_bank == `GPH_BANK_USER)
                  go_mem = 1'b1;
               else
                  next_status = `GPH_ST_BAD_VAL;
            end
            `GPH_OP_HOME:
            begin
               if (c_bank != 8'h00)
                  next_status = `GPH_ST_BAD_VAL;
               else if (c_type == `GPH_HOME_START)
                  hs_start = 1'b1;
               else if (c_type == `GPH_HOME_STOP)
                  hs_stop = 1'b1;
               else if (c_type == `GPH_HOME_STATUS)
                  next_value = {31'h0, home == HS_RUN};
               else
                  next_status = `GPH_ST_BAD_TYPE;
            end
            `GPH_OP_SET_OUT:
            begin
               if (c_bank != `GPH_BANK_USER)
                  next_status = `GPH_ST_BAD_VAL;
               else if (c_type == `GPH_OUT_ALL)
               begin
                  sio_mask = 8'hff;
                  if (c_val == `GPH_VAL_ACCU)
                  begin
                     sio_we  = 1'b1;
                     sio_val = accu[7:0];
                  end
                  else if (c_val[31:8] == 24'h000000)
                  begin
                     sio_we  = 1'b1;
                     sio_val = c_val[7:0];
                  end
                  else
                     next_status = `GPH_ST_BAD_VAL;
               end
               else if (c_type < `GPH_OUT_LINES)
               begin
                  sio_mask = 8'h01 << c_type[2:0];
                  sio_val  = {8{c_val[0]}};
                  if (c_val[31:1] == 31'h0)
                     sio_we = 1'b1;
                  else
                     next_status = `GPH_ST_BAD_VAL;
               end
               else
                  next_status = `GPH_ST_BAD_TYPE;
            end
            default:
               next_status = `GPH_ST_BAD_CMD;
         endcase
      end
   end

   // main sequence
   always_comb
   begin
      next_state = state;
      case (state)
         ST_BOOT:
            next_state = RESTORE_EN ? ST_RD : ST_RX;
         ST_RX:
            if (frame_end && (fb[0] == MOD_ADDR))
               next_state = ST_EXEC;
         ST_EXEC:
            next_state = go_mem ? ST_RD : ST_TX;
         ST_RD:
            next_state = ST_WR;
         ST_WR:
            if (mop != MOP_BOOT)
               next_state = ST_TX;
            else if (cur_addr[7:0] == 8'hff)
               next_state = ST_RX;
            else
               next_state = ST_RD;
         ST_TX:
            if (tx_step && (tx_idx == `GPH_LAST_IDX))
               next_state = ST_RX;
         default:
            next_state = ST_RX;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_BOOT;
         busy  <= 1'b1;
      end
      else if (ce)
      begin
         state <= next_state;
         busy  <= (next_state != ST_RX);
      end
   end

   // memory operation and address
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mop      <= MOP_BOOT;
         cur_addr <= 10'({`GPH_BANK_USER, 8'h00});
      end
      else if (ce)
      begin
         if (state == ST_EXEC)
         begin
            mop      <= next_mop;
            cur_addr <= next_addr;
         end
         else if ((state == ST_WR) && (mop == MOP_BOOT))
            cur_addr <= cur_addr + 10'h001;
      end
   end

   // working copy: frame ops, reloads and parameter writes
   always_comb
   begin
      work_if.addr  = cur_addr;
      work_if.we    = 1'b0;
      work_if.wdata = nv_if.rdata;
      if ((state == ST_WR) && ((mop == MOP_RESTORE) || (mop == MOP_BOOT)))
         work_if.we = 1'b1;
      else if ((state == ST_RX) && gp_wr_valid && bank_ok(gp_wr_bank))
      begin
         work_if.addr  = gp_addr(gp_wr_bank, gp_wr_type);
         work_if.we    = 1'b1;
         work_if.wdata = gp_wr_data;
      end
   end

   // nonvolatile copy
   always_comb
   begin
      nv_if.addr  = cur_addr;
      nv_if.we    = 1'b0;
      nv_if.wdata = work_if.rdata;
      if ((state == ST_WR) && (mop == MOP_STORE))
         nv_if.we = 1'b1;
      else if ((state == ST_RX) && gp_wr_valid && (gp_wr_bank == `GPH_BANK_GLOBAL))
      begin
         nv_if.addr  = gp_addr(gp_wr_bank, gp_wr_type);
         nv_if.we    = 1'b1;
         nv_if.wdata = gp_wr_data;
      end
   end

   // accumulator and reply fields
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         accu     <= `GPH_ACCU_RST;
         r_status <= `GPH_ST_OK;
         r_value  <= 32'h00000000;
      end
      else if (ce)
      begin
         if (state == ST_EXEC)
         begin
            r_status <= next_status;
            r_value  <= next_value;
         end
         else if ((state == ST_WR) && (mop == MOP_READ))
         begin
            accu    <= work_if.rdata;
            r_value <= work_if.rdata;
         end
      end
   end

   // general purpose outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         out_lines <= `GPH_DOUT_RST;
      else if (ce && (state == ST_EXEC) && sio_we)
         out_lines <= (out_lines & ~sio_mask) | (sio_val & sio_mask);
   end

   // home search state machine
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         home        <= HS_IDLE;
         home_active <= 1'b0;
      end
      else if (ce)
      begin
         case (home)
            HS_IDLE:
               if ((state == ST_EXEC) && hs_start)
               begin
                  home        <= HS_RUN;
                  home_active <= 1'b1;
               end
            HS_RUN:
               if (((state == ST_EXEC) && hs_stop) || home_s2)
               begin
                  home        <= HS_IDLE;
                  home_active <= 1'b0;
               end
            default:
            begin
               home        <= HS_IDLE;
               home_active <= 1'b0;
            end
         endcase
      end
   end

   // reply bytes in frame order
   function automatic logic [7:0] reply_byte(input logic [3:0] idx);
      case (idx)
         4'h0:    return HOST_ADDR;
         4'h1:    return MOD_ADDR;
         4'h2:    return r_status;
         4'h3:    return c_instr;
         4'h4:    return r_value[31:24];
         4'h5:    return r_value[23:16];
         4'h6:    return r_value[15:8];
         default: return r_value[7:0];
      endcase
   endfunction

   // reply transmit
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         tx_idx   <= 4'h0;
         tx_sum   <= 8'h00;
      end
      else if (ce)
      begin
         if (tx_go)
         begin
            tx_valid <= 1'b1;
            tx_data  <= HOST_ADDR;
            tx_sum   <= HOST_ADDR;
            tx_idx   <= 4'h0;
         end
         else if (tx_step)
         begin
            if (tx_idx == `GPH_LAST_IDX)
               tx_valid <= 1'b0;
            else if (tx_idx == 4'h7)
               tx_data <= tx_sum;
            else
            begin
               tx_data <= reply_byte(tx_idx + 4'h1);
               tx_sum  <= tx_sum + reply_byte(tx_idx + 4'h1);
            end
            tx_idx <= tx_idx + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/gph_top_sva.sv */
`default_nettype none
module gph_top_sva #(
   parameter logic [7:0] MOD_ADDR  = 8'h01,
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       ce,
   // command and reply streams
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   // status
   input wire logic       home_found,
   input wire logic       home_active,
   input wire logic [7:0] out_lines,
   input wire logic       busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [7:0] fb [8];
   logic [7:0] sum;
   logic       take;
   logic       last;
   logic       ok_frame;
   logic       line_ok;
   assign take = ce && rx_valid && !busy;
   assign last = take && cnt == 4'h8;
   assign sum = fb[0] + fb[1] + fb[2] + fb[3] + fb[4] + fb[5] + fb[6] + fb[7];
   assign ok_frame = last && fb[0] == MOD_ADDR && sum == rx_data;
   assign line_ok = out_lines[fb[2][2:0]] == fb[7][0];
   // frame byte position
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt <= 4'h0;
      else if (take)
         cnt <= last ? 4'h0 : cnt + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (take && !last)
         fb[cnt[2:0]] <= rx_data;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_read;
      ok_frame && fb[1] == 8'h0a && fb[3] == 8'h00;
   endsequence
   sequence s_fast;
      ok_frame && fb[1] inside {8'h0d, 8'h0e};
   endsequence
   sequence s_home(logic [7:0] t);
      ok_frame && fb[1] == 8'h0d && fb[2] == t && fb[3] == 8'h00;
   endsequence
   sequence s_line;
      ok_frame && fb[1] == 8'h0e && fb[3] == 8'h02 && fb[2] < 8'h08
         && {fb[4], fb[5], fb[6], fb[7][7:1]} == 31'h0;
   endsequence
   chk_reply_mem: assert property (s_read |-> ##[4:5] $rose(tx_valid))
      else $error("read reply late");
   chk_reply_fast: assert property (s_fast |-> ##[2:3] $rose(tx_valid))
      else $error("reply late");
   chk_foreign_silent: assert property (last && fb[0] != MOD_ADDR |=> !tx_valid [*8])
      else $error("reply to foreign frame");
   chk_bad_frame: assert property (last && sum != rx_data |=> $stable(out_lines) [*6])
      else $error("bad frame acted on");
   chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped");
   chk_reply_head: assert property ($rose(tx_valid) |-> tx_data == HOST_ADDR)
      else $error("reply header wrong");
   chk_home_start: assert property (s_home(8'h00) |-> ##[1:2] home_active)
      else $error("search not started");
   chk_home_stop: assert property (s_home(8'h01) |-> ##[1:2] !home_active)
      else $error("search not stopped");
   chk_home_pin: assert property (home_found [*5] |-> !home_active)
      else $error("search not ended by pin");
   chk_line_set: assert property (s_line |-> ##[1:2] line_ok)
      else $error("line not set");
   chk_idle_quiet: assert property (!busy |-> !tx_valid)
      else $error("reply while idle");
endmodule
`default_nettype wire

/* bench/gph_host.sv */
`default_nettype none
module gph_host #(
   parameter logic [7:0] MOD_ADDR = 8'h01
) (
   // clock and status
   input  wire logic       clk,
   input  wire logic       busy,
   // command stream
   output var logic        rx_valid,
   output var logic [7:0]  rx_data,
   // reply stream
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var logic        tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       slow = 1'b0;
   logic       tmo  = 1'b0;
   logic [7:0] rep [9];
   initial
   begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b0;
   end
   // accepts every other cycle when slow
   always @(negedge clk)
      tx_ready <= slow ? !tx_ready : 1'b1;
   task automatic idle;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (busy !== 1'b0 && n < 2000);
      tmo = tmo || (n >= 2000);
   endtask
   task automatic cmd(input logic [7:0] a, op, ty, bk, input logic [31:0] v, input bit bad);
      logic [7:0] fr [9];
      int         k;
      int         n;
      fr = '{a, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      for (k = 0; k < 8; k++)
         fr[8] += fr[k];
      fr[8] ^= {7'h00, bad};
      idle();
      for (k = 0; k < 9; k++)
      begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data  = fr[k];
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data  = ~fr[8];
      k = 0;
      n = 0;
      while (a == MOD_ADDR && k < 9 && n < 400)
      begin
         @(posedge clk);
         n++;
         if (tx_valid === 1'b1 && tx_ready === 1'b1)
         begin
            rep[k] = tx_data;
            k++;
         end
      end
      tmo = tmo || (a == MOD_ADDR && k < 9);
   endtask
endmodule
`default_nettype wire

/* bench/gph_top_tb.sv */
`default_nettype none
module global_param_homing_output_cmds_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk         = 1'b0;
   logic        rstn        = 1'b0;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_ready;
   logic        gp_wr_valid = 1'b0;
   logic [7:0]  gp_wr_bank  = 8'h00;
   logic [7:0]  gp_wr_type  = 8'h00;
   logic [31:0] gp_wr_data  = 32'h0;
   logic        home_found  = 1'b0;
   logic        home_active;
   logic [7:0]  out_lines;
   logic [31:0] accu;
   logic        busy;
   int          n_errors    = 0;
   int          checks_done = 0;
   always #25 clk = ~clk;
   gph_top u_dut (
      .clk(clk), .rstn(rstn), .ce(1'b1), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .gp_wr_valid(gp_wr_valid), .gp_wr_bank(gp_wr_bank), .gp_wr_type(gp_wr_type),
      .gp_wr_data(gp_wr_data), .home_found(home_found), .home_active(home_active),
      .out_lines(out_lines), .accu(accu), .busy(busy)
   );
   gph_host u_host (
      .clk(clk), .busy(busy), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
   );
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (exp !== got)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic run(input logic [7:0] op, ty, bk, input logic [31:0] v,
                      input logic [7:0] st, input logic [31:0] ev, input bit cv);
      logic [7:0] r [9];
      logic [7:0] s;
      u_host.cmd(8'h01, op, ty, bk, v, st == 8'h01);
      if (u_host.tmo)
      begin
         n_errors++;
         final_report();
      end
      r = u_host.rep;
      s = 8'h00;
      for (int k = 0; k < 8; k++)
         s += r[k];
      chk("reply head", {8'h02, 8'h01, st, op}, {r[0], r[1], r[2], r[3]});
      chk("reply sum", {24'h0, s}, {24'h0, r[8]});
      if (cv)
         chk("reply value", ev, {r[4], r[5], r[6], r[7]});
   endtask
   task automatic gp_write(input logic [7:0] bk, ty, input logic [31:0] d);
      u_host.idle();
      gp_wr_valid = 1'b1;
      gp_wr_bank  = bk;
      gp_wr_type  = ty;
      gp_wr_data  = d;
      @(negedge clk);
      gp_wr_valid = 1'b0;
   endtask
   task automatic t_params;
      gp_write(8'h00, 8'h42, 32'h3);
      run(8'h0a, 8'h42, 8'h00, 32'h0, 8'h64, 32'h3, 1);
      chk("accu", 32'h3, accu);
      gp_write(8'h03, 8'h05, 32'h1234_5678);
      run(8'h0a, 8'h05, 8'h03, 32'h0, 8'h64, 32'h1234_5678, 1);
      run(8'h0a, 8'h05, 8'h01, 32'h0, 8'h04, 32'h0, 0);
   endtask
   task automatic t_user;
      gp_write(8'h02, 8'h2a, 32'hcafe_0042);
      run(8'h0b, 8'h2a, 8'h02, 32'h5555_5555, 8'h64, 32'h0, 0);
      gp_write(8'h02, 8'h2a, 32'h0bad_0001);
      run(8'h0a, 8'h2a, 8'h02, 32'h0, 8'h64, 32'h0bad_0001, 1);
      run(8'h0c, 8'h2a, 8'h02, 32'h0, 8'h64, 32'h0, 0);
      run(8'h0a, 8'h2a, 8'h02, 32'h0, 8'h64, 32'hcafe_0042, 1);
   endtask
   task automatic t_home;
      u_host.slow = 1'b1;
      run(8'h0d, 8'h00, 8'h00, 32'h0, 8'h64, 32'h0, 0);
      chk("home active", 32'h1, {31'h0, home_active});
      run(8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 32'h1, 1);
      run(8'h0d, 8'h01, 8'h00, 32'h0, 8'h64, 32'h0, 0);
      run(8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 32'h0, 1);
      run(8'h0d, 8'h00, 8'h00, 32'h0, 8'h64, 32'h0, 0);
      @(negedge clk);
      home_found = 1'b1;
      repeat (6) @(negedge clk);
      home_found = 1'b0;
      run(8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 32'h0, 1);
      run(8'h0d, 8'h00, 8'h01, 32'h0, 8'h04, 32'h0, 0);
      u_host.slow = 1'b0;
   endtask
   task automatic t_out;
      logic [7:0] e;
      e = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         run(8'h0e, 8'(i), 8'h02, 32'h1, 8'h64, 32'h0, 0);
         e[i] = 1'b1;
         chk("line set", {24'h0, e}, {24'h0, out_lines});
      end
      run(8'h0e, 8'h03, 8'h02, 32'h0, 8'h64, 32'h0, 0);
      chk("line clear", 32'hf7, {24'h0, out_lines});
      run(8'h0e, 8'h08, 8'h02, 32'h1, 8'h03, 32'h0, 0);
      run(8'h0e, 8'hff, 8'h02, 32'h5a, 8'h64, 32'h0, 0);
      chk("all lines", 32'h5a, {24'h0, out_lines});
      run(8'h0a, 8'h42, 8'h00, 32'h0, 8'h64, 32'h3, 1);
      run(8'h0e, 8'hff, 8'h02, 32'hffff_ffff, 8'h64, 32'h0, 0);
      chk("lines from accu", 32'h3, {24'h0, out_lines});
   endtask
   task automatic t_errs;
      int n;
      run(8'h0e, 8'hff, 8'h02, 32'ha5, 8'h01, 32'h0, 0);
      chk("lines kept", 32'h3, {24'h0, out_lines});
      run(8'h20, 8'h00, 8'h00, 32'h0, 8'h02, 32'h0, 0);
      u_host.cmd(8'h07, 8'h0e, 8'hff, 8'h02, 32'h0, 0);
      n = 0;
      repeat (12)
      begin
         @(posedge clk);
         if (tx_valid !== 1'b0)
            n++;
      end
      chk("foreign reply", 32'h0, n);
      chk("foreign lines", 32'h3, {24'h0, out_lines});
   endtask
   task automatic t_boot;
      @(negedge clk);
      rstn = 1'b0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      run(8'h0a, 8'h2a, 8'h02, 32'h0, 8'h64, 32'hcafe_0042, 1);
   endtask
   initial
   begin
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      t_params();
      t_user();
      t_home();
      t_out();
      t_errs();
      t_boot();
      final_report();
   end
endmodule
bind gph_top gph_top_sva #(.MOD_ADDR(MOD_ADDR), .HOST_ADDR(HOST_ADDR)) u_sva (
   .clk(clk), .rstn(rstn), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .home_found(home_found),
   .home_active(home_active), .out_lines(out_lines), .busy(busy)
);
`default_nettype wire
